/* hw/pcp_pkg.sv */
package pcp_pkg;

  // indirect port addresses in ordinary register space
  localparam logic [7:0] ADDR_DATA   = 8'he2;
  localparam logic [7:0] ADDR_ADRH   = 8'he3;
  localparam logic [7:0] ADDR_ADRL   = 8'he4;
  localparam logic [7:0] ADDR_MODE   = 8'he5;
  localparam logic [7:0] ADDR_TRIG   = 8'he6;
  localparam logic [7:0] ADDR_CTRL   = 8'he7;

  // protected page offsets
  localparam logic [7:0] OFS_IAPLOW  = 8'h03;
  localparam logic [7:0] OFS_OSCSEL  = 8'h40;
  localparam logic [7:0] OFS_WDSEL   = 8'h41;
  localparam logic [7:0] OFS_RTCSEL  = 8'h42;
  localparam logic [7:0] OFS_BOD     = 8'h44;
  localparam logic [7:0] OFS_VREF    = 8'h45;
  localparam logic [7:0] OFS_WPROT   = 8'h48;

  // reset values
  localparam logic [7:0] RST_IAPLOW  = 8'h36;
  localparam logic [7:0] RST_OSCSEL  = 8'h50;
  localparam logic [7:0] RST_WDSEL   = 8'h02;
  localparam logic [7:0] RST_RTCSEL  = 8'h00;
  localparam logic [7:0] RST_BOD     = 8'h05;
  localparam logic [7:0] RST_VREF    = 8'h00;
  localparam logic [7:0] RST_WPROT   = 8'h00;

  // fixed bits of mixed registers
  localparam logic [7:0] WDSEL_MASK  = 8'hdc;
  localparam logic [7:0] WDSEL_FIXED = 8'h02;
  localparam logic [7:0] BOD_MASK    = 8'hbe;
  localparam logic [7:0] BOD_FIXED   = 8'h01;
  localparam logic [7:0] VREF_MASK   = 8'h80;

  // trigger bytes and mode codes
  localparam logic [7:0] TRIG_FIRST  = 8'h46;
  localparam logic [7:0] TRIG_SECOND = 8'hb9;
  localparam logic [7:0] MODE_PWRITE = 8'h04;
  localparam logic [7:0] MODE_PREAD  = 8'h05;
  localparam logic [7:0] PAGE_HIGH   = 8'h00;

  // control register bit positions
  localparam int CTRL_EN_BIT   = 7;
  localparam int CTRL_FAIL_BIT = 4;

  localparam logic [7:0] IAP_PAGE_SHIFT = 8'h08;
  localparam int         STALL_CYCLES   = 2;

  typedef enum logic [1:0] {
    PCP_IDLE  = 2'b00,
    PCP_ARMED = 2'b01,
    PCP_BUSY  = 2'b10
  } pcp_phase_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcp_bus_type;

  typedef struct packed {
    logic [1:0] crystal_gain_sel;
    logic       crystal_osc_enable;
    logic       fast_rc_enable;
    logic [1:0] main_clock_source_sel;
    logic       multiplier_enable;
    logic [1:0] osc_input_source_sel;
    logic       crystal_pins_as_gpio;
    logic [1:0] watchdog_clock_sel;
    logic       watchdog_event_bit_sel;
    logic [1:0] main_clock_divider_sel;
    logic [2:0] rtc_source_sel;
    logic [4:0] rtc_prescale_sel;
    logic       detector2_keep_awake;
    logic [1:0] detector2_level_sel;
    logic       detector2_enable;
    logic       voltage_ref_enable;
    logic [7:0] page_write_protect;
    logic [15:0] iap_low_addr;
    logic [15:0] iap_high_addr;
  } pcp_cfg_type;

endpackage

/* hw/pcp_config_page.sv */
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
// How it works
// - page-write mode copies data into indexed register
// - page-read mode copies indexed register into data
// - enable bit plus ordered trigger pair starts op
// - region low is boundary times 256
// - crystal gain field selects low or high gain
// - crystal disabled frees pins as port bits
// - main clock source field selects input or multiplier
// - oscillator input field picks four sources
// - watchdog clock field picks three sources
// - watchdog event bit picks counter bit 8/0
// - divider field divides main clock by 1-8
// - rtc source field picks five sources
// - keep-awake bit holds detector two in power-down
// - detector two level field, loaded from option bits
// - detector two flag resets when enabled
// - detector two enable bit powers detector
// - detector one flag resets when enabled
// - reference enable bit powers 1.4 V reference
// - enable bit clear refuses every indirect access
// - fail flag shows last command failure
// - cpu stalled until indirect operation completes
module pcp_config_page #(
  parameter logic [15:0] BOOT_START = 16'h3a00
) (
  input  wire  logic                 mclk,
  input  wire  logic                 srst,
  input  wire  pcp_pkg::pcp_bus_type bus,
  output logic [7:0]                 rdata,
  output logic                       cpu_stall,
  input  wire  logic [1:0]           bod_level_option,
  input  wire  logic                 detector1_flag,
  input  wire  logic                 detector2_flag,
  output logic                       brownout_reset,
  output pcp_pkg::pcp_cfg_type       cfg
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    pcp_pkg::pcp_phase_type phase;
    logic [1:0]             stall_cnt;
    logic                   strap_done;
    logic [7:0]             data;
    logic [7:0]             adrh;
    logic [7:0]             adrl;
    logic [7:0]             mode;
    logic                   enable;
    logic                   fail;
    logic [7:0]             iaplow;
    logic [7:0]             oscsel;
    logic [7:0]             wdsel;
    logic [7:0]             rtcsel;
    logic [7:0]             bod;
    logic [7:0]             vref;
    logic [7:0]             wprot;
    logic [1:0]             f1_sync;
    logic [1:0]             f2_sync;
    logic                   bor;
    logic [7:0]             rdata;
  } pcp_state_type;

  pcp_state_type state_reg;
  pcp_state_type state_next;

  logic       page_hit;
  logic [7:0] page_val;
  logic       trig_wr;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    page_hit = 1'b1;
    unique case (state_reg.adrl)
      pcp_pkg::OFS_IAPLOW: page_val = state_reg.iaplow;
      pcp_pkg::OFS_OSCSEL: page_val = state_reg.oscsel;
      pcp_pkg::OFS_WDSEL:  page_val = state_reg.wdsel;
      pcp_pkg::OFS_RTCSEL: page_val = state_reg.rtcsel;
      pcp_pkg::OFS_BOD:    page_val = state_reg.bod;
      pcp_pkg::OFS_VREF:   page_val = state_reg.vref;
      pcp_pkg::OFS_WPROT:  page_val = state_reg.wprot;
      default: begin
        page_val = 8'h00;
        page_hit = 1'b0;
      end
    endcase
  end

  assign trig_wr = bus.wr && bus.addr == pcp_pkg::ADDR_TRIG;

  always_comb begin
    state_next = state_reg;
    // option bits captured on the first clocked cycle after reset
    if (!state_reg.strap_done) begin
      state_next.strap_done = 1'b1;
      state_next.bod[5:4]   = bod_level_option;
    end
    // two-flop synchronisers; analog flags are asynchronous
    state_next.f1_sync = {state_reg.f1_sync[0], detector1_flag};
    state_next.f2_sync = {state_reg.f2_sync[0], detector2_flag};
    state_next.bor = (state_reg.f1_sync[1] && state_reg.bod[1])
                   || (state_reg.f2_sync[1] && state_reg.bod[3]);

    // only the indirect ports are visible; page offsets never decode
    if (bus.wr && state_reg.phase != pcp_pkg::PCP_BUSY) begin
      unique case (bus.addr)
        pcp_pkg::ADDR_DATA: state_next.data = bus.wdata;
        pcp_pkg::ADDR_ADRH: state_next.adrh = bus.wdata;
        pcp_pkg::ADDR_ADRL: state_next.adrl = bus.wdata;
        pcp_pkg::ADDR_MODE: state_next.mode = bus.wdata;
        pcp_pkg::ADDR_CTRL: begin
          state_next.enable = bus.wdata[pcp_pkg::CTRL_EN_BIT];
          state_next.fail   = bus.wdata[pcp_pkg::CTRL_FAIL_BIT];
        end
        default: ;
      endcase
    end

    unique case (bus.addr)
      pcp_pkg::ADDR_DATA: state_next.rdata = state_reg.data;
      pcp_pkg::ADDR_ADRH: state_next.rdata = state_reg.adrh;
      pcp_pkg::ADDR_ADRL: state_next.rdata = state_reg.adrl;
      pcp_pkg::ADDR_MODE: state_next.rdata = state_reg.mode;
      pcp_pkg::ADDR_CTRL: state_next.rdata = {state_reg.enable, 2'b00,
                                              state_reg.fail, 4'h0};
      default:            state_next.rdata = 8'h00;
    endcase

    unique case (state_reg.phase)
      pcp_pkg::PCP_IDLE: begin
        if (trig_wr && bus.wdata == pcp_pkg::TRIG_FIRST) begin
          state_next.phase = pcp_pkg::PCP_ARMED;
        end
      end
      pcp_pkg::PCP_ARMED: begin
        // any other bus write or read between the bytes breaks the pair
        if (bus.wr || bus.rd) begin
          state_next.phase = pcp_pkg::PCP_IDLE;
          if (trig_wr && bus.wdata == pcp_pkg::TRIG_SECOND) begin
            state_next.phase     = pcp_pkg::PCP_BUSY;
            state_next.stall_cnt = 2'(pcp_pkg::STALL_CYCLES - 1);
          end else if (trig_wr && bus.wdata == pcp_pkg::TRIG_FIRST) begin
            state_next.phase = pcp_pkg::PCP_ARMED;
          end
        end
      end
      pcp_pkg::PCP_BUSY: begin
        if (state_reg.stall_cnt != 2'b00) begin
          state_next.stall_cnt = state_reg.stall_cnt - 2'b01;
        end else begin
          state_next.phase = pcp_pkg::PCP_IDLE;
          state_next.fail  = 1'b1;
          if (state_reg.enable && page_hit
              && state_reg.adrh == pcp_pkg::PAGE_HIGH) begin
            if (state_reg.mode == pcp_pkg::MODE_PWRITE) begin
              state_next.fail = 1'b0;
              unique case (state_reg.adrl)
                pcp_pkg::OFS_IAPLOW: state_next.iaplow = state_reg.data;
                pcp_pkg::OFS_OSCSEL: state_next.oscsel = state_reg.data;
                pcp_pkg::OFS_WDSEL:  state_next.wdsel =
                  (state_reg.data & pcp_pkg::WDSEL_MASK)
                  | pcp_pkg::WDSEL_FIXED;
                pcp_pkg::OFS_RTCSEL: state_next.rtcsel = state_reg.data;
                pcp_pkg::OFS_BOD:    state_next.bod =
                  (state_reg.data & pcp_pkg::BOD_MASK)
                  | pcp_pkg::BOD_FIXED;
                pcp_pkg::OFS_VREF:   state_next.vref =
                  state_reg.data & pcp_pkg::VREF_MASK;
                default:             state_next.wprot = state_reg.data;
              endcase
            end else if (state_reg.mode == pcp_pkg::MODE_PREAD) begin
              state_next.fail = 1'b0;
              // boundary register is write-only and reads back zero
              state_next.data = state_reg.adrl == pcp_pkg::OFS_IAPLOW
                              ? 8'h00 : page_val;
            end
          end
        end
      end
      default: state_next.phase = pcp_pkg::PCP_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg            <= '0;
      state_reg.phase      <= pcp_pkg::PCP_IDLE;
      state_reg.iaplow     <= pcp_pkg::RST_IAPLOW;
      state_reg.oscsel     <= pcp_pkg::RST_OSCSEL;
      state_reg.wdsel      <= pcp_pkg::RST_WDSEL;
      state_reg.rtcsel     <= pcp_pkg::RST_RTCSEL;
      state_reg.bod        <= pcp_pkg::RST_BOD;
      state_reg.vref       <= pcp_pkg::RST_VREF;
      state_reg.wprot      <= pcp_pkg::RST_WPROT;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign rdata          = state_reg.rdata;
  assign cpu_stall      = state_reg.phase == pcp_pkg::PCP_BUSY;
  assign brownout_reset = state_reg.bor;

  always_comb begin
    cfg.crystal_gain_sel       = state_reg.oscsel[7:6];
    cfg.crystal_osc_enable     = state_reg.oscsel[5];
    cfg.crystal_pins_as_gpio   = !state_reg.oscsel[5];
    cfg.fast_rc_enable         = state_reg.oscsel[4];
    cfg.main_clock_source_sel  = state_reg.oscsel[3:2];
    // multiplier must run for any non-zero source code
    cfg.multiplier_enable      = state_reg.oscsel[3:2] != 2'b00;
    cfg.osc_input_source_sel   = state_reg.oscsel[1:0];
    cfg.watchdog_clock_sel     = state_reg.wdsel[7:6];
    cfg.watchdog_event_bit_sel = state_reg.wdsel[4];
    cfg.main_clock_divider_sel = state_reg.wdsel[3:2];
    cfg.rtc_source_sel         = state_reg.rtcsel[7:5];
    cfg.rtc_prescale_sel       = state_reg.rtcsel[4:0];
    cfg.detector2_keep_awake   = state_reg.bod[7];
    cfg.detector2_level_sel    = state_reg.bod[5:4];
    cfg.detector2_enable       = state_reg.bod[2];
    cfg.voltage_ref_enable     = state_reg.vref[7];
    cfg.page_write_protect     = state_reg.wprot;
    cfg.iap_low_addr  = {state_reg.iaplow, 8'h00};
    cfg.iap_high_addr = BOOT_START - 16'h0001;
  end

endmodule // pcp_config_page

/* test/pcp_config_page_chk.sv */
`timescale 1ns/1ns
module pcp_config_page_chk #(
  parameter logic [15:0] BOOT_START = 16'h3a00
) (
  input wire logic                 mclk,
  input wire logic                 srst,
  input wire pcp_pkg::pcp_bus_type bus,
  input wire logic [7:0]           rdata,
  input wire logic                 cpu_stall,
  input wire logic [1:0]           bod_level_option,
  input wire logic                 detector1_flag,
  input wire logic                 detector2_flag,
  input wire logic                 brownout_reset,
  input wire pcp_pkg::pcp_cfg_type cfg
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  logic        trig2;
  logic [23:0] pick;
  assign trig2 = bus.wr && bus.addr == pcp_pkg::ADDR_TRIG
                 && bus.wdata == pcp_pkg::TRIG_SECOND;
  // a sample of page fields; the level field is left out, option load moves it
  assign pick = {cfg.crystal_gain_sel, cfg.watchdog_clock_sel,
                 cfg.rtc_source_sel, cfg.voltage_ref_enable, cfg.iap_low_addr};
  ////////////////////////////////////////////////////////////////////////////
  sequence s_stall_pair;
    cpu_stall ##1 !cpu_stall;
  endsequence
  a_stall_two_cycles: assert property ($rose(cpu_stall) |=> s_stall_pair)
    else $error("stall length wrong");
  a_stall_cause: assert property ($rose(cpu_stall) |-> $past(trig2) || $past(trig2, 2))
    else $error("stall without second trigger byte");
  a_cfg_on_done: assert property ($changed(pick) |-> $fell(cpu_stall))
    else $error("page field changed outside an operation");
  a_iap_high_fixed: assert property (cfg.iap_high_addr == BOOT_START - 16'h0001)
    else $error("region top wrong");
  a_iap_low_page: assert property (cfg.iap_low_addr[7:0] == 8'h00)
    else $error("region bottom not page aligned");
  a_xtal_pins_gpio: assert property (cfg.crystal_pins_as_gpio == !cfg.crystal_osc_enable)
    else $error("crystal pin mode wrong");
  a_mult_follows: assert property (cfg.multiplier_enable == (cfg.main_clock_source_sel != 2'b00))
    else $error("multiplier enable wrong");
  a_bor_quiet: assert property ((!detector1_flag && !detector2_flag) [*4] |-> !brownout_reset)
    else $error("brownout reset without flag");
endmodule // pcp_config_page_chk

bind pcp_config_page pcp_config_page_chk #(.BOOT_START(BOOT_START))
  pcp_config_page_chk_inst (.mclk(mclk), .srst(srst), .bus(bus),
  .rdata(rdata), .cpu_stall(cpu_stall), .bod_level_option(bod_level_option),
  .detector1_flag(detector1_flag), .detector2_flag(detector2_flag),
  .brownout_reset(brownout_reset), .cfg(cfg));

/* test/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic                 mclk = 1'b0;
  logic                 srst = 1'b1;
  pcp_pkg::pcp_bus_type bus = '0;
  logic [7:0]           rdata;
  logic                 cpu_stall;
  logic [1:0]           bod_opt = 2'b10;
  logic                 flag1 = 1'b0;
  logic                 flag2 = 1'b0;
  logic                 bor;
  pcp_pkg::pcp_cfg_type cfg;
  int                   n_errors = 0;
  int                   samples_checked = 0;
  int                   cyc = 0;
  logic [7:0]           got;
  logic                 fail;
  always #4 mclk = ~mclk;
  pcp_config_page pcp_config_page_inst (.mclk(mclk), .srst(srst), .bus(bus),
    .rdata(rdata), .cpu_stall(cpu_stall), .bod_level_option(bod_opt),
    .detector1_flag(flag1), .detector2_flag(flag2),
    .brownout_reset(bor), .cfg(cfg));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one idle cycle between writes keeps each strobe a clean single pulse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge mclk);
    bus.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge mclk);
    bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge mclk);
    d = rdata;
    bus.rd = 1'b0;
  endtask
  task automatic setup(input logic [7:0] en, hi, md, ofs, din);
    wr(pcp_pkg::ADDR_CTRL, en);
    wr(pcp_pkg::ADDR_ADRH, hi);
    wr(pcp_pkg::ADDR_ADRL, ofs);
    wr(pcp_pkg::ADDR_MODE, md);
    wr(pcp_pkg::ADDR_DATA, din);
    wr(pcp_pkg::ADDR_TRIG, pcp_pkg::TRIG_FIRST);
  endtask
  task automatic page(input logic [7:0] en, hi, md, ofs, din);
    logic [7:0] c;
    setup(en, hi, md, ofs, din);
    wr(pcp_pkg::ADDR_TRIG, pcp_pkg::TRIG_SECOND);
    chk(cpu_stall, 1'b1);
    @(negedge mclk);
    chk(cpu_stall, 1'b1);
    @(negedge mclk);
    chk(cpu_stall, 1'b0);
    repeat (2) @(negedge mclk);
    rd(pcp_pkg::ADDR_CTRL, c);
    fail = c[pcp_pkg::CTRL_FAIL_BIT];
    rd(pcp_pkg::ADDR_DATA, got);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] o[7] = '{8'h03, 8'h40, 8'h41, 8'h42, 8'h44, 8'h45, 8'h48};
    logic [7:0] e[7] = '{8'h00, 8'h50, 8'h02, 8'h00, 8'h25, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++) begin
      page(8'h80, 8'h00, pcp_pkg::MODE_PREAD, o[i], 8'h00);
      chk(got, e[i]);
      chk(fail, 1'b0);
    end
    chk(cfg.iap_low_addr, 16'h3600);
    chk(cfg.iap_high_addr, 16'h39ff);
    chk(cfg.detector2_level_sel, bod_opt);
    $display("test reset values done");
  endtask
  task automatic t_write();
    logic [7:0] o[7] = '{8'h03, 8'h40, 8'h41, 8'h42, 8'h44, 8'h45, 8'h48};
    // boundary 0x38 is even and stays below the boot region
    logic [7:0] w[7] = '{8'h38, 8'h6e, 8'hff, 8'ha5, 8'hff, 8'hff, 8'h5a};
    logic [7:0] e[7] = '{8'h00, 8'h6e, 8'hde, 8'ha5, 8'hbf, 8'h80, 8'h5a};
    for (int i = 0; i < 7; i++) begin
      page(8'h80, 8'h00, pcp_pkg::MODE_PWRITE, o[i], w[i]);
      page(8'h80, 8'h00, pcp_pkg::MODE_PREAD, o[i], 8'h00);
      chk(got, e[i]);
    end
    chk({cfg.crystal_gain_sel, cfg.crystal_osc_enable, cfg.fast_rc_enable,
         cfg.main_clock_source_sel, cfg.osc_input_source_sel}, 8'h6e);
    chk({cfg.watchdog_clock_sel, cfg.watchdog_event_bit_sel,
         cfg.main_clock_divider_sel}, 5'h1f);
    chk(cfg.rtc_source_sel, 3'b101);
    chk({cfg.detector2_keep_awake, cfg.detector2_level_sel,
         cfg.detector2_enable, cfg.voltage_ref_enable}, 5'h1f);
    chk(cfg.iap_low_addr, 16'h3800);
    chk(cfg.crystal_pins_as_gpio, 1'b0);
    $display("test page writes done");
  endtask
  task automatic t_refuse();
    logic [7:0] en[3] = '{8'h00, 8'h80, 8'h80};
    logic [7:0] hi[3] = '{8'h00, 8'h01, 8'h00};
    logic [7:0] md[3] = '{8'h04, 8'h04, 8'h03};
    for (int i = 0; i < 3; i++) begin
      page(en[i], hi[i], md[i], pcp_pkg::OFS_WPROT, 8'h11);
      chk(fail, 1'b1);
      chk(cfg.page_write_protect, 8'h5a);
    end
    page(8'h80, 8'h00, pcp_pkg::MODE_PWRITE, pcp_pkg::OFS_WPROT, 8'h77);
    chk(fail, 1'b0);
    wr(pcp_pkg::OFS_WPROT, 8'h00);
    setup(8'h80, 8'h00, pcp_pkg::MODE_PWRITE, pcp_pkg::OFS_WPROT, 8'h99);
    rd(pcp_pkg::ADDR_CTRL, got);
    wr(pcp_pkg::ADDR_TRIG, pcp_pkg::TRIG_SECOND);
    wr(pcp_pkg::ADDR_TRIG, pcp_pkg::TRIG_FIRST);
    wr(pcp_pkg::ADDR_TRIG, 8'hb8);
    repeat (4) @(negedge mclk);
    chk(cfg.page_write_protect, 8'h77);
    $display("test refusals done");
  endtask
  task automatic t_bor();
    page(8'h80, 8'h00, pcp_pkg::MODE_PWRITE, pcp_pkg::OFS_BOD, 8'h03);
    flag1 = 1'b1;
    repeat (5) @(negedge mclk);
    chk(bor, 1'b1);
    flag1 = 1'b0;
    flag2 = 1'b1;
    repeat (5) @(negedge mclk);
    chk(bor, 1'b0);
    page(8'h80, 8'h00, pcp_pkg::MODE_PWRITE, pcp_pkg::OFS_BOD, 8'h0d);
    chk(bor, 1'b1);
    flag2 = 1'b0;
    repeat (5) @(negedge mclk);
    chk(bor, 1'b0);
    $display("test brownout done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // a hang costs at most this many cycles; the full run needs about 640
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    srst = 1'b0;
    t_reset();
    t_write();
    t_refuse();
    t_bor();
    wrap_up();
  end
endmodule // tb_top
